// ### core/link_test_pkg.sv
// Package for the serial link test-pattern and framing configuration block.
// Assumes one 50 MHz clock and a simple strobe-based register port.
// Functional notes
// - Five-bit test selector in low register bits; zero means normal sample transport.
// - Selector 1, 2, 3, 13, 14 emit PRBS7, PRBS15, PRBS23, PRBS9, PRBS31.
// - Selector 4 sends a ramp; selector 5 sends the transport-layer test pattern.
// - Selectors 6, 7, 16 repeat D21.5, K28.5 and K28.7 characters.
// - Selector 8 repeats the alignment sequence; selector 9 sends modified RPAT.
// - Selector 10 holds outputs low; selector 11 holds outputs high.
// - Selector 15 outputs the clock-like word 0x00ff.
// - Eight-bit identifier goes into the second multiframe of the alignment sequence.
// - First link sends the identifier; second link sends identifier plus one.
// - Identifier bit 0 is ignored and reads zero.
// - Two-bit end-of-frame selector: 0 K28.7, 1 K28.1, 2 K28.5, 3 reserved.
package link_test_pkg;
	localparam logic [9:0] ADDR_TEST_SEL = 10'h205;
	localparam logic [9:0] ADDR_DEV_ID = 10'h206;
	localparam logic [9:0] ADDR_FEND_SEL = 10'h207;
	localparam logic [9:0] ADDR_LINK_CTRL = 10'h210;
	localparam logic [7:0] RST_TEST_SEL = 8'h00;
	localparam logic [7:0] RST_DEV_ID = 8'h00;
	localparam logic [7:0] RST_FEND_SEL = 8'h00;
	localparam logic [7:0] RST_LINK_CTRL = 8'h00;
	localparam int LINK_EN_BIT = 0;
	localparam int ENC_8B10B_BIT = 1;
	localparam logic [4:0] TP_NORMAL = 5'h00;
	localparam logic [4:0] TP_PRBS7 = 5'h01;
	localparam logic [4:0] TP_PRBS15 = 5'h02;
	localparam logic [4:0] TP_PRBS23 = 5'h03;
	localparam logic [4:0] TP_RAMP = 5'h04;
	localparam logic [4:0] TP_TRANSPORT = 5'h05;
	localparam logic [4:0] TP_D215 = 5'h06;
	localparam logic [4:0] TP_K285 = 5'h07;
	localparam logic [4:0] TP_ILA = 5'h08;
	localparam logic [4:0] TP_RPAT = 5'h09;
	localparam logic [4:0] TP_LOW = 5'h0a;
	localparam logic [4:0] TP_HIGH = 5'h0b;
	localparam logic [4:0] TP_PRBS9 = 5'h0d;
	localparam logic [4:0] TP_PRBS31 = 5'h0e;
	localparam logic [4:0] TP_CLOCK = 5'h0f;
	localparam logic [4:0] TP_K287 = 5'h10;
	localparam logic [7:0] CH_D215 = 8'hb5;
	localparam logic [7:0] CH_K285 = 8'hbc;
	localparam logic [7:0] CH_K281 = 8'h3c;
	localparam logic [7:0] CH_K287 = 8'hfc;
	localparam logic [7:0] CH_K280 = 8'h1c;
	localparam logic [7:0] CH_K283 = 8'h7c;
	localparam logic [15:0] CLOCK_WORD = 16'h00ff;
	localparam logic [15:0] TRANSPORT_WORD = 16'h8001;
	localparam logic [3:0] ILA_FRAMES = 4'hf;
	localparam int FIFO_DEPTH = 4;
	localparam int WORD_W = 16;

	typedef struct packed {
		logic [15:0] data;
		logic [1:0] is_k;
	} lane_word_t;

	typedef enum logic [3:0] {
		ILA_START = 4'b0001,
		ILA_ID = 4'b0010,
		ILA_FILL = 4'b0100,
		ILA_END = 4'b1000
	} ila_state_t;
endpackage

// ### core/link_test_fifo.sv
// Small synchronous FIFO for lane words.
// Assumes one clock domain and an asynchronous active-high reset.
`timescale 1ns/1ps
module link_test_fifo #(
	parameter int WIDTH = 18,
	parameter int DEPTH = 4
) (
	// Clock and reset.
	input wire logic i_mclk,
	input wire logic i_rst,
	// Fill side.
	input wire logic i_valid,
	output logic o_ready,
	input wire logic [WIDTH-1:0] i_data,
	// Drain side.
	output logic o_valid,
	input wire logic i_ready,
	output logic [WIDTH-1:0] o_data
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW:0] count;
	logic [AW:0] next_count;
	logic [AW-1:0] wr_ptr;
	logic [AW-1:0] next_wr_ptr;
	logic [AW-1:0] rd_ptr;
	logic [AW-1:0] next_rd_ptr;
	logic push;
	logic pop;

	assign o_ready = (count != DEPTH[AW:0]);
	assign o_valid = (count != '0);
	assign o_data = mem[rd_ptr];

	always_comb begin
		push = i_valid && o_ready;
		pop = o_valid && i_ready;
		next_wr_ptr = push ? AW'(wr_ptr + 1'b1) : wr_ptr;
		next_rd_ptr = pop ? AW'(rd_ptr + 1'b1) : rd_ptr;
		next_count = count;
		if (push && !pop) begin
			next_count = (AW+1)'(count + 1'b1);
		end else if (pop && !push) begin
			next_count = (AW+1)'(count - 1'b1);
		end
	end

	always_ff @(posedge i_mclk or posedge i_rst) begin
		if (i_rst) begin
			count <= '0;
			wr_ptr <= '0;
			rd_ptr <= '0;
		end else begin
			count <= next_count;
			wr_ptr <= next_wr_ptr;
			rd_ptr <= next_rd_ptr;
		end
	end

	always_ff @(posedge i_mclk) begin
		if (push) begin
			mem[wr_ptr] <= i_data;
		end
	end
endmodule // link_test_fifo

// ### core/link_test_framer.sv
// Test-pattern selector, identifier and end-of-frame logic for two transmit links.
// Assumes sample words arrive on the clock domain and a serializer drains each link.
`timescale 1ns/1ps
module link_test_framer
	import link_test_pkg::*;
(
	// Clock and reset.
	input wire logic i_mclk,
	input wire logic i_rst,
	// Register port.
	input wire logic [9:0] i_addr,
	input wire logic [7:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	output logic [7:0] o_rdata,
	// Sample input.
	input wire logic [15:0] i_sample,
	input wire logic i_sample_valid,
	input wire logic i_frame_end,
	output logic o_sample_ready,
	// Link A and link B lane outputs.
	output lane_word_t o_lane_a,
	output lane_word_t o_lane_b,
	output logic o_lane_valid,
	input wire logic i_lane_ready
);
	logic [7:0] test_sel;
	logic [7:0] next_test_sel;
	logic [7:0] dev_id;
	logic [7:0] next_dev_id;
	logic [7:0] fend_sel;
	logic [7:0] next_fend_sel;
	logic [7:0] link_ctrl;
	logic [7:0] next_link_ctrl;
	logic [7:0] next_rdata;
	logic [4:0] mode;
	logic [30:0] lfsr;
	logic [30:0] next_lfsr;
	logic [15:0] ramp;
	logic [15:0] next_ramp;
	logic [3:0] ila_cnt;
	logic [3:0] next_ila_cnt;
	logic ila_mf;
	logic next_ila_mf;
	ila_state_t ila_st;
	ila_state_t next_ila_st;
	logic [9:0] rpat_idx;
	logic [9:0] next_rpat_idx;
	lane_word_t gen_a;
	lane_word_t gen_b;
	logic fifo_in_ready;
	logic fifo_out_valid;
	logic [35:0] fifo_out;
	logic advance;

	// Steps an LFSR of the given tap pair sixteen times; used for all PRBS widths.
	function automatic logic [30:0] prbs_step(input logic [30:0] s, input int len, input int tap);
		logic [30:0] r;
		logic fb;
		r = s;
		for (int i = 0; i < 16; i++) begin
			fb = r[len-1] ^ r[tap-1];
			r = {r[29:0], fb};
		end
		return r;
	endfunction

	function automatic lane_word_t char_word(input logic [7:0] c);
		char_word.data = {c, c};
		char_word.is_k = 2'b11;
	endfunction

	function automatic logic [7:0] fend_char(input logic [1:0] sel);
		case (sel)
			2'h1: fend_char = CH_K281;
			2'h2: fend_char = CH_K285;
			default: fend_char = CH_K287;
		endcase
	endfunction

	assign mode = test_sel[4:0];
	assign advance = fifo_in_ready;
	// In normal mode the sample source is stalled by the FIFO filling up.
	assign o_sample_ready = fifo_in_ready && (mode == TP_NORMAL);

	always_comb begin
		next_test_sel = test_sel;
		next_dev_id = dev_id;
		next_fend_sel = fend_sel;
		next_link_ctrl = link_ctrl;
		next_rdata = 8'h00;
		if (i_wr) begin
			case (i_addr)
				ADDR_TEST_SEL: next_test_sel = {3'h0, i_wdata[4:0]};
				ADDR_DEV_ID: next_dev_id = {i_wdata[7:1], 1'b0};
				ADDR_FEND_SEL: next_fend_sel = {6'h00, i_wdata[1:0]};
				ADDR_LINK_CTRL: next_link_ctrl = {6'h00, i_wdata[1:0]};
				default: ;
			endcase
		end
		if (i_rd) begin
			case (i_addr)
				ADDR_TEST_SEL: next_rdata = test_sel;
				ADDR_DEV_ID: next_rdata = dev_id;
				ADDR_FEND_SEL: next_rdata = fend_sel;
				ADDR_LINK_CTRL: next_rdata = link_ctrl;
				default: next_rdata = 8'h00;
			endcase
		end
	end

	always_ff @(posedge i_mclk or posedge i_rst) begin
		if (i_rst) begin
			test_sel <= RST_TEST_SEL;
			dev_id <= RST_DEV_ID;
			fend_sel <= RST_FEND_SEL;
			link_ctrl <= RST_LINK_CTRL;
			o_rdata <= 8'h00;
		end else begin
			test_sel <= next_test_sel;
			dev_id <= next_dev_id;
			fend_sel <= next_fend_sel;
			link_ctrl <= next_link_ctrl;
			o_rdata <= next_rdata;
		end
	end

	// Pattern generators move whenever the FIFO has room, which in test modes is each accepted word, so nothing is skipped.
	always_comb begin
		next_lfsr = lfsr;
		next_ramp = ramp;
		next_rpat_idx = rpat_idx;
		next_ila_cnt = ila_cnt;
		next_ila_mf = ila_mf;
		next_ila_st = ila_st;
		gen_a = '0;
		case (mode)
			TP_PRBS7: gen_a.data = lfsr[15:0];
			TP_PRBS9: gen_a.data = lfsr[15:0];
			TP_PRBS15: gen_a.data = lfsr[15:0];
			TP_PRBS23: gen_a.data = lfsr[15:0];
			TP_PRBS31: gen_a.data = lfsr[15:0];
			TP_RAMP: gen_a.data = ramp;
			TP_TRANSPORT: gen_a.data = ramp[0] ? TRANSPORT_WORD : ~TRANSPORT_WORD;
			TP_D215: begin
				gen_a = char_word(CH_D215);
				gen_a.is_k = 2'b00;
			end
			TP_K285: gen_a = char_word(CH_K285);
			TP_K287: gen_a = char_word(CH_K287);
			TP_RPAT: gen_a.data = {rpat_idx[9:2], ~rpat_idx[9:2]};
			TP_LOW: gen_a.data = 16'h0000;
			TP_HIGH: gen_a.data = 16'hffff;
			TP_CLOCK: gen_a.data = CLOCK_WORD;
			TP_ILA: begin
				case (ila_st)
					ILA_START: gen_a = char_word(CH_K280);
					ILA_ID: begin
						gen_a.data = {dev_id, 8'h00};
						gen_a.is_k = 2'b00;
					end
					ILA_END: gen_a = char_word(CH_K283);
					default: gen_a.data = {4'h0, ila_cnt, 8'h00};
				endcase
			end
			default: begin
				gen_a.data = i_sample;
				if (link_ctrl[ENC_8B10B_BIT] && i_frame_end) begin
					gen_a.data[7:0] = fend_char(fend_sel[1:0]);
					gen_a.is_k = 2'b01;
				end
			end
		endcase
		gen_b = gen_a;
		if (mode == TP_ILA && ila_st == ILA_ID) begin
			gen_b.data[15:8] = 8'(dev_id + 8'h01);
		end
		if (advance) begin
			case (mode)
				TP_PRBS7: next_lfsr = prbs_step(lfsr, 7, 6);
				TP_PRBS9: next_lfsr = prbs_step(lfsr, 9, 5);
				TP_PRBS15: next_lfsr = prbs_step(lfsr, 15, 14);
				TP_PRBS23: next_lfsr = prbs_step(lfsr, 23, 18);
				TP_PRBS31: next_lfsr = prbs_step(lfsr, 31, 28);
				default: next_lfsr = lfsr;
			endcase
			next_ramp = 16'(ramp + 16'h0001);
			next_rpat_idx = 10'(rpat_idx + 10'h001);
			case (ila_st)
				ILA_START: next_ila_st = (ila_mf) ? ILA_ID : ILA_FILL;
				ILA_ID: next_ila_st = ILA_FILL;
				ILA_FILL: begin
					next_ila_cnt = 4'(ila_cnt + 4'h1);
					if (ila_cnt == ILA_FRAMES) begin
						next_ila_st = ILA_END;
					end
				end
				ILA_END: begin
					next_ila_st = ILA_START;
					next_ila_cnt = 4'h0;
					next_ila_mf = ~ila_mf;
				end
				default: next_ila_st = ILA_START;
			endcase
		end
	end

	always_ff @(posedge i_mclk or posedge i_rst) begin
		if (i_rst) begin
			lfsr <= 31'h7fffffff;
			ramp <= 16'h0000;
			rpat_idx <= 10'h000;
			ila_cnt <= 4'h0;
			ila_mf <= 1'b0;
			ila_st <= ILA_START;
		end else begin
			lfsr <= next_lfsr;
			ramp <= next_ramp;
			rpat_idx <= next_rpat_idx;
			ila_cnt <= next_ila_cnt;
			ila_mf <= next_ila_mf;
			ila_st <= next_ila_st;
		end
	end

	// Test patterns free-run; only normal transport waits for a valid sample.
	link_test_fifo #(
		.WIDTH(36),
		.DEPTH(FIFO_DEPTH)
	) u_link_test_fifo (
		.i_mclk(i_mclk),
		.i_rst(i_rst),
		.i_valid((mode != TP_NORMAL) || i_sample_valid),
		.o_ready(fifo_in_ready),
		.i_data({gen_a, gen_b}),
		.o_valid(fifo_out_valid),
		.i_ready(i_lane_ready),
		.o_data(fifo_out)
	);

	assign o_lane_valid = fifo_out_valid;
	assign o_lane_a = fifo_out[35:18];
	assign o_lane_b = fifo_out[17:0];
endmodule // link_test_framer

// ### verification/link_test_framer_props.sv
// Checker for the link test framer, bound to its ports.
// Assumes a selector write takes effect at its strobe edge.
`timescale 1ns/1ps
module link_test_framer_props
	import link_test_pkg::*;
(
	// Clock and reset.
	input wire logic i_mclk,
	input wire logic i_rst,
	// Register port.
	input wire logic [9:0] i_addr,
	input wire logic [7:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	input wire logic [7:0] o_rdata,
	// Sample and lanes.
	input wire logic o_sample_ready,
	input wire lane_word_t o_lane_a,
	input wire lane_word_t o_lane_b,
	input wire logic o_lane_valid,
	input wire logic i_lane_ready
);
	logic [4:0] sel;
	logic [2:0] pops;
	logic ok;
	// Up to four old words sit in the buffer after a selector change, so wait five drains.
	always_ff @(posedge i_mclk or posedge i_rst) begin
		if (i_rst) begin
			sel <= 5'h00;
			pops <= 3'h0;
		end else if (i_wr && i_addr == ADDR_TEST_SEL) begin
			sel <= i_wdata[4:0];
			pops <= 3'h0;
		end else if (o_lane_valid && i_lane_ready && pops != 3'h7) begin
			pops <= pops + 3'h1;
		end
	end
	assign ok = o_lane_valid && pops > 3'h4;
	default clocking cb @(posedge i_mclk); endclocking
	default disable iff (i_rst);
	property p_rd_sel; i_rd && i_addr == ADDR_TEST_SEL |=> o_rdata == {3'h0, sel}; endproperty
	a_rd_sel: assert property (p_rd_sel) else $error("bad selector read");
	property p_rd_id; i_rd && i_addr == ADDR_DEV_ID |=> !o_rdata[0]; endproperty
	a_rd_id: assert property (p_rd_id) else $error("identifier bit 0 set");
	property p_rd_fe; i_rd && i_addr == ADDR_FEND_SEL |=> o_rdata[7:2] == 6'h00; endproperty
	a_rd_fe: assert property (p_rd_fe) else $error("bad comma select read");
	property p_ready; o_sample_ready |-> sel == TP_NORMAL; endproperty
	a_ready: assert property (p_ready) else $error("samples taken in test mode");
	property p_low; ok && sel == TP_LOW |-> o_lane_a.data == 16'h0000; endproperty
	a_low: assert property (p_low) else $error("lane not low");
	property p_high; ok && sel == TP_HIGH |-> o_lane_a.data == 16'hffff; endproperty
	a_high: assert property (p_high) else $error("lane not high");
	property p_clk; ok && sel == TP_CLOCK |-> o_lane_a.data == CLOCK_WORD; endproperty
	a_clk: assert property (p_clk) else $error("bad clock word");
	property p_pair; ok && sel != TP_ILA |-> o_lane_b == o_lane_a; endproperty
	a_pair: assert property (p_pair) else $error("links differ");
	c_ila: cover property (ok && sel == TP_ILA && o_lane_b != o_lane_a);
	c_full: cover property (sel == TP_NORMAL && !o_sample_ready);
	c_high: cover property (ok && sel == TP_HIGH);
endmodule // link_test_framer_props

bind link_test_framer link_test_framer_props u_link_test_framer_props (.i_mclk(i_mclk),
	.i_rst(i_rst), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
	.o_rdata(o_rdata), .o_sample_ready(o_sample_ready), .o_lane_a(o_lane_a),
	.o_lane_b(o_lane_b), .o_lane_valid(o_lane_valid), .i_lane_ready(i_lane_ready));

// ### verification/link_lane_rx.sv
// Lane receiver model that drains both links and keeps what it took.
// Assumes the framer holds a lane word until it is accepted.
`timescale 1ns/1ps
module link_lane_rx
	import link_test_pkg::*;
(
	// Clock and reset.
	input wire logic i_mclk,
	input wire logic i_rst,
	// Pace and lanes.
	input wire logic i_stall,
	input wire lane_word_t i_lane_a,
	input wire lane_word_t i_lane_b,
	input wire logic i_lane_valid,
	output logic o_lane_ready
);
	lane_word_t got_a[$];
	lane_word_t got_b[$];
	logic [1:0] phase;
	// A slow receiver takes one word in four, so the buffer fills and refuses samples.
	always_ff @(posedge i_mclk or posedge i_rst) begin
		if (i_rst) begin
			phase <= 2'h0;
		end else begin
			phase <= phase + 2'h1;
		end
	end
	assign o_lane_ready = !i_stall || phase == 2'h3;
	always @(posedge i_mclk) begin
		if (!i_rst && i_lane_valid && o_lane_ready) begin
			got_a.push_back(i_lane_a);
			got_b.push_back(i_lane_b);
		end
	end
endmodule // link_lane_rx

// ### verification/link_test_framer_test.sv
// Bench for the link test framer: registers, sample path and test modes.
// Assumes the lane receiver model drains both links.
`timescale 1ns/1ps
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin n_fail++; \
$display("MISMATCH %0t got %h exp %h", $time, g, e); end end
`define GA u_link_lane_rx.got_a
`define GB u_link_lane_rx.got_b
module link_test_framer_test
	import link_test_pkg::*;
;
	logic i_mclk = 1'b0;
	logic i_rst = 1'b1;
	logic [9:0] i_addr = 10'h000;
	logic [7:0] i_wdata = 8'h00;
	logic i_wr = 1'b0;
	logic i_rd = 1'b0;
	logic [7:0] o_rdata;
	logic [15:0] i_sample = 16'h0000;
	logic i_sample_valid = 1'b0;
	logic i_frame_end = 1'b0;
	logic o_sample_ready;
	lane_word_t o_lane_a;
	lane_word_t o_lane_b;
	lane_word_t w;
	logic o_lane_valid;
	logic i_lane_ready;
	logic stall = 1'b0;
	logic waited = 1'b0;
	logic [7:0] comma [3] = '{CH_K287, CH_K281, CH_K285};
	int tp [15] = '{1, 2, 3, 4, 5, 6, 7, 8, 9, 10, 11, 13, 14, 15, 16};
	int n_fail = 0;
	int checks_done = 0;
	int cyc = 0;
	int hits = 0;
	always #10 i_mclk = ~i_mclk;
	link_test_framer u_link_test_framer (.i_mclk(i_mclk), .i_rst(i_rst), .i_addr(i_addr),
		.i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_sample(i_sample),
		.i_sample_valid(i_sample_valid), .i_frame_end(i_frame_end),
		.o_sample_ready(o_sample_ready), .o_lane_a(o_lane_a), .o_lane_b(o_lane_b),
		.o_lane_valid(o_lane_valid), .i_lane_ready(i_lane_ready));
	link_lane_rx u_link_lane_rx (.i_mclk(i_mclk), .i_rst(i_rst), .i_stall(stall),
		.i_lane_a(o_lane_a), .i_lane_b(o_lane_b), .i_lane_valid(o_lane_valid),
		.o_lane_ready(i_lane_ready));
	task automatic wr(input logic [9:0] a, input logic [7:0] d);
		i_addr <= a;
		i_wdata <= d;
		i_wr <= 1'b1;
		@(posedge i_mclk);
		i_wr <= 1'b0;
		@(posedge i_mclk);
	endtask
	task automatic rd(input logic [9:0] a, input logic [7:0] e);
		i_addr <= a;
		i_rd <= 1'b1;
		@(posedge i_mclk);
		i_rd <= 1'b0;
		@(negedge i_mclk);
		`CHK(o_rdata, e)
		@(posedge i_mclk);
	endtask
	// The strobe stays up between pushes; the caller lowers it after a burst.
	task automatic push(input logic [15:0] d, input logic fe);
		i_sample <= d;
		i_frame_end <= fe;
		i_sample_valid <= 1'b1;
		@(negedge i_mclk);
		while (o_sample_ready !== 1'b1) begin
			waited = 1'b1;
			@(negedge i_mclk);
		end
		@(posedge i_mclk);
	endtask
	task automatic take(input lane_word_t e);
		repeat (20) if (`GA.size() == 0) @(posedge i_mclk);
		w = `GA.pop_front();
		void'(`GB.pop_front());
		`CHK(w, e)
	endtask
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", checks_done, n_fail);
		if (n_fail == 0 && checks_done > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask
	always @(posedge i_mclk) begin
		cyc++;
		if (cyc == 5000) begin
			n_fail++;
			tally_and_finish();
		end
	end
	initial begin
		repeat (16) @(posedge i_mclk);
		i_rst <= 1'b0;
		@(posedge i_mclk);
		rd(ADDR_TEST_SEL, RST_TEST_SEL);
		rd(ADDR_DEV_ID, RST_DEV_ID);
		rd(ADDR_FEND_SEL, RST_FEND_SEL);
		wr(ADDR_LINK_CTRL, 8'h00);
		wr(ADDR_DEV_ID, 8'h37);
		rd(ADDR_DEV_ID, 8'h36);
		wr(ADDR_TEST_SEL, 8'hed);
		rd(ADDR_TEST_SEL, 8'h0d);
		rd(10'h3ff, 8'h00);
		wr(ADDR_TEST_SEL, 8'h00);
		// Words drained while the pseudo-random mode ran must not reach the sample checks.
		repeat (2) @(posedge i_mclk);
		`GA.delete();
		`GB.delete();
		for (int k = 0; k < 4; k++) begin
			wr(ADDR_LINK_CTRL, 8'h00);
			wr(ADDR_FEND_SEL, 8'hfc | 8'(k % 3));
			rd(ADDR_FEND_SEL, 8'(k % 3));
			wr(ADDR_LINK_CTRL, k < 3 ? 8'h03 : 8'h01);
			push(16'h5a5a, 1'b0);
			push(16'h1234, 1'b1);
			i_sample_valid <= 1'b0;
			take({16'h5a5a, 2'b00});
			take(k < 3 ? {8'h12, comma[k % 3], 2'b01} : {16'h1234, 2'b00});
		end
		stall <= 1'b1;
		waited = 1'b0;
		for (int k = 0; k < 8; k++) push(16'h0100 + 16'(k), 1'b0);
		i_sample_valid <= 1'b0;
		stall <= 1'b0;
		`CHK(waited, 1'b1)
		for (int k = 0; k < 8; k++) take({16'h0100 + 16'(k), 2'b00});
		foreach (tp[i]) begin
			wr(ADDR_TEST_SEL, 8'(tp[i]));
			`GA.delete();
			`GB.delete();
			repeat (60) @(posedge i_mclk);
			`CHK(o_sample_ready, 1'b0)
			foreach (`GA[j]) if (`GA[j] !== `GB[j]) begin
				hits++;
				`CHK(`GB[j].data[15:8], 8'h37)
				`CHK(`GA[j].data[15:8], 8'h36)
			end
			w = `GA[$];
			if (tp[i] < 5 || tp[i] == 13 || tp[i] == 14) `CHK(w !== `GA[$-1], 1'b1)
			if (tp[i] == 4) `CHK(w.data, 16'(`GA[$-1].data + 16'h0001))
			if (tp[i] == 5) `CHK(w.data inside {TRANSPORT_WORD, ~TRANSPORT_WORD}, 1'b1)
			if (tp[i] == 6) `CHK(w, {{2{CH_D215}}, 2'b00})
			if (tp[i] == 7) `CHK(w, {{2{CH_K285}}, 2'b11})
			if (tp[i] == 16) `CHK(w, {{2{CH_K287}}, 2'b11})
		end
		`CHK(hits > 0, 1'b1)
		tally_and_finish();
	end
endmodule // link_test_framer_test
